// >>> core/gpc_port_cfg.sv
// pin configuration sub-registers of one port, reached through selector and window
//
// Contract
// - selector 04H routes window reads and writes to the high drive register.
// - high drive bit 1 gives high current, 0 gives standard current.
// - high drive acts on the pin, also while an alternate function owns it.
// - selector 05H routes window accesses to the stop-mode wake source register.
// - in stop, any edge on an enabled wake pin starts recovery; others never. Here edges are ignored until the synchroniser chain has filled after reset.
// - selector 06H routes window accesses to the pull-up enable register.
// - pull-up bit 1 switches the weak pull-up on, 0 switches it off.
// - selector 07H routes window accesses to alternate select low register.
// - selector 08H routes window accesses to alternate select high register.
// - select bits act on a pin only when its alternate enable bit is set.
// - select registers reset to 00H, or 04H on port A of the small package.
// - selector 00H and 09H to FFH map nothing; window writes are dropped.
// - low and high select bits of a pin together choose one of four functions.
// - with alternate enable set, the chosen function owns the pin.
`timescale 1ns/1ps
module gpc_port_cfg #(
    parameter bit SMALL_PORT_A = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // address selector access
    input wire logic sel_wr_i,
    input wire logic [gpc_pkg::GPC_DW-1:0] sel_wdata_i,
    output logic [gpc_pkg::GPC_DW-1:0] sel_rdata_o,
    // control window access
    input wire logic win_wr_i,
    input wire logic [gpc_pkg::GPC_DW-1:0] win_wdata_i,
    output logic [gpc_pkg::GPC_DW-1:0] win_rdata_o,
    // neighbouring port logic
    input wire logic [gpc_pkg::GPC_PINS-1:0] alt_function_enable_bit_i,
    input wire logic stop_mode_i,
    // pins
    input wire logic [gpc_pkg::GPC_PINS-1:0] pin_i,
    output logic [gpc_pkg::GPC_PINS-1:0] high_drive_o,
    output logic [gpc_pkg::GPC_PINS-1:0] pullup_en_o,
    output logic [gpc_pkg::GPC_PINS-1:0] alt_active_o,
    output logic [2*gpc_pkg::GPC_PINS-1:0] alt_sel_o,
    output logic stop_recover_o
);
    import gpc_pkg::*;

    localparam logic [7:0] ALT_RST = SMALL_PORT_A ? GPC_RST_ALT_SMALL_PORT_A : GPC_RST_ALT_WIDE;

    // register file
    logic [7:0] selector_r;
    logic [7:0] selector_nxt;
    logic [7:0] pin_high_drive_enable_r;
    logic [7:0] pin_high_drive_enable_nxt;
    logic [7:0] stop_wake_source_enable_r;
    logic [7:0] stop_wake_source_enable_nxt;
    logic [7:0] pin_pullup_enable_r;
    logic [7:0] pin_pullup_enable_nxt;
    logic [7:0] alt_func_select_low_r;
    logic [7:0] alt_func_select_low_nxt;
    logic [7:0] alt_func_select_high_r;
    logic [7:0] alt_func_select_high_nxt;

    // outputs
    logic [7:0] win_rdata_r;
    logic [7:0] win_rdata_nxt;
    logic [7:0] alt_active_r;
    logic [7:0] alt_active_nxt;
    logic [15:0] alt_sel_r;
    logic [15:0] alt_sel_nxt;
    logic stop_recover_r;
    logic stop_recover_nxt;

    // decode of the selector that was in place before this cycle's write
    logic hit_hde;
    logic hit_wake;
    logic hit_pue;
    logic hit_low;
    logic hit_high;

    gpc_wake_if wk ();

    gpc_wake_detect u_wake (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pin_i),
        .wk(wk)
    );

    assign wk.wake_src = stop_wake_source_enable_r;
    assign wk.stop_mode = stop_mode_i;

    always_comb begin
        hit_hde = (selector_r == GPC_SEL_HIGH_DRIVE);
        hit_wake = (selector_r == GPC_SEL_WAKE_SRC);
        hit_pue = (selector_r == GPC_SEL_PULLUP);
        hit_low = (selector_r == GPC_SEL_ALT_LOW);
        hit_high = (selector_r == GPC_SEL_ALT_HIGH);
    end

    // register writes; a window write in the same cycle as a selector write uses the old selector
    always_comb begin
        selector_nxt = sel_wr_i ? sel_wdata_i : selector_r;
        pin_high_drive_enable_nxt = pin_high_drive_enable_r;
        stop_wake_source_enable_nxt = stop_wake_source_enable_r;
        pin_pullup_enable_nxt = pin_pullup_enable_r;
        alt_func_select_low_nxt = alt_func_select_low_r;
        alt_func_select_high_nxt = alt_func_select_high_r;
        // unmapped selectors fall through and store nothing
        if (win_wr_i) begin
            if (hit_hde) begin
                pin_high_drive_enable_nxt = win_wdata_i;
            end
            if (hit_wake) begin
                stop_wake_source_enable_nxt = win_wdata_i;
            end
            if (hit_pue) begin
                pin_pullup_enable_nxt = win_wdata_i;
            end
            if (hit_low) begin
                alt_func_select_low_nxt = win_wdata_i;
            end
            if (hit_high) begin
                alt_func_select_high_nxt = win_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            selector_r <= GPC_RST_SELECTOR;
            pin_high_drive_enable_r <= GPC_RST_HIGH_DRIVE;
            stop_wake_source_enable_r <= GPC_RST_WAKE_SRC;
            pin_pullup_enable_r <= GPC_RST_PULLUP;
            alt_func_select_low_r <= ALT_RST;
            alt_func_select_high_r <= ALT_RST;
        end else begin
            selector_r <= selector_nxt;
            pin_high_drive_enable_r <= pin_high_drive_enable_nxt;
            stop_wake_source_enable_r <= stop_wake_source_enable_nxt;
            pin_pullup_enable_r <= pin_pullup_enable_nxt;
            alt_func_select_low_r <= alt_func_select_low_nxt;
            alt_func_select_high_r <= alt_func_select_high_nxt;
        end
    end

    // window read data follows the selected register one cycle later;
    // codes 01H-03H belong to other port logic and read as zero here
    always_comb begin
        win_rdata_nxt = GPC_READ_UNMAPPED;
        if (hit_hde) begin
            win_rdata_nxt = pin_high_drive_enable_r;
        end else if (hit_wake) begin
            win_rdata_nxt = stop_wake_source_enable_r;
        end else if (hit_pue) begin
            win_rdata_nxt = pin_pullup_enable_r;
        end else if (hit_low) begin
            win_rdata_nxt = alt_func_select_low_r;
        end else if (hit_high) begin
            win_rdata_nxt = alt_func_select_high_r;
        end
    end

    // per pin alternate function choice, gated by its enable
    genvar gi;
    generate
        for (gi = 0; gi < GPC_PINS; gi++) begin : g_pin
            always_comb begin
                alt_active_nxt[gi] = alt_function_enable_bit_i[gi];
                if (alt_function_enable_bit_i[gi]) begin
                    alt_sel_nxt[2*gi+:2] = {alt_func_select_high_r[gi],
                                            alt_func_select_low_r[gi]};
                end else begin
                    alt_sel_nxt[2*gi+:2] = GPC_ALT_IDLE;
                end
            end

            chk_alt_gate_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
                !alt_active_o[gi] |-> alt_sel_o[2*gi+:2] == GPC_ALT_IDLE)
                else $error("alternate select leaks onto a disabled pin");

            chk_alt_pair_code: assert property (@(posedge clk_i) disable iff (!arst_n_i)
                ##1 alt_active_o[gi] |-> alt_sel_o[2*gi+:2] ==
                    {$past(alt_func_select_high_r[gi]), $past(alt_func_select_low_r[gi])})
                else $error("alternate select code does not match select bits");
        end
    endgenerate

    // a hit is registered so the recovery request leaves from a flop
    always_comb begin
        stop_recover_nxt = wk.wake_hit;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            win_rdata_r <= GPC_READ_UNMAPPED;
            alt_active_r <= 8'h00;
            alt_sel_r <= 16'h0000;
            stop_recover_r <= 1'b0;
        end else begin
            win_rdata_r <= win_rdata_nxt;
            alt_active_r <= alt_active_nxt;
            alt_sel_r <= alt_sel_nxt;
            stop_recover_r <= stop_recover_nxt;
        end
    end

    // drive and pull-up come straight from their registers, not through the alternate path,
    // so they keep acting while an alternate function owns the pin
    assign high_drive_o = pin_high_drive_enable_r;
    assign pullup_en_o = pin_pullup_enable_r;
    assign sel_rdata_o = selector_r;
    assign win_rdata_o = win_rdata_r;
    assign alt_active_o = alt_active_r;
    assign alt_sel_o = alt_sel_r;
    assign stop_recover_o = stop_recover_r;

    // helper: low only in the first cycle after reset release
    logic seen_clk_r;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_clk_r <= 1'b0;
        end else begin
            seen_clk_r <= 1'b1;
        end
    end

    chk_hde_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_HIGH_DRIVE |=>
            pin_high_drive_enable_r == $past(win_wdata_i))
        else $error("high drive register missed a window write");

    chk_drive_pin_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_HIGH_DRIVE |=> high_drive_o == $past(win_wdata_i))
        else $error("high drive pins do not follow the written bits");

    chk_drive_ignores_alt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !win_wr_i && $changed(alt_function_enable_bit_i) |=> $stable(high_drive_o))
        else $error("high drive changed with alternate enable");

    chk_wake_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_WAKE_SRC |=>
            stop_wake_source_enable_r == $past(win_wdata_i))
        else $error("wake source register missed a window write");

    chk_wake_only_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        stop_recover_o |-> $past(stop_mode_i) && $past(stop_wake_source_enable_r) != 8'h00)
        else $error("recovery raised outside stop or with no source");

    chk_pullup_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_PULLUP |=> pullup_en_o == $past(win_wdata_i))
        else $error("pull-up enables do not follow the written bits");

    chk_alt_low_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_ALT_LOW |=>
            alt_func_select_low_r == $past(win_wdata_i))
        else $error("select low register missed a window write");

    chk_alt_high_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && selector_r == GPC_SEL_ALT_HIGH |=>
            alt_func_select_high_r == $past(win_wdata_i))
        else $error("select high register missed a window write");

    chk_alt_reset_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !seen_clk_r |-> alt_func_select_low_r == ALT_RST && alt_func_select_high_r == ALT_RST
            && pin_high_drive_enable_r == 8'h00 && pin_pullup_enable_r == 8'h00)
        else $error("select or drive register left reset with a wrong value");

    chk_unmapped_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        win_wr_i && (selector_r == GPC_SEL_NONE || selector_r > GPC_SEL_ALT_HIGH) |=>
            $stable(pin_high_drive_enable_r) && $stable(stop_wake_source_enable_r)
            && $stable(pin_pullup_enable_r) && $stable(alt_func_select_low_r)
            && $stable(alt_func_select_high_r))
        else $error("write through an unmapped selector changed a register");

    chk_alt_active_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 alt_active_o == $past(alt_function_enable_bit_i))
        else $error("alternate ownership does not follow its enable");

    chk_read_select: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_PULLUP |=> win_rdata_o == $past(pin_pullup_enable_r))
        else $error("window read did not return the selected register");

    chk_read_unmapped: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r > GPC_SEL_ALT_HIGH |=> win_rdata_o == GPC_READ_UNMAPPED)
        else $error("unmapped selector read returned data");

    chk_read_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_NONE |=> win_rdata_o == GPC_READ_UNMAPPED)
        else $error("empty selector read returned data");

    chk_read_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_HIGH_DRIVE |=> win_rdata_o == $past(pin_high_drive_enable_r))
        else $error("window read did not return the high drive register");

    chk_read_wake: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_WAKE_SRC |=> win_rdata_o == $past(stop_wake_source_enable_r))
        else $error("window read did not return the wake source register");

    chk_read_alt_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_ALT_LOW |=> win_rdata_o == $past(alt_func_select_low_r))
        else $error("window read did not return the select low register");

    chk_read_alt_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        selector_r == GPC_SEL_ALT_HIGH |=> win_rdata_o == $past(alt_func_select_high_r))
        else $error("window read did not return the select high register");

endmodule : gpc_port_cfg

// >>> core/gpc_wake_detect.sv
// pin synchroniser and any-edge detector for stop-mode recovery
`timescale 1ns/1ps
module gpc_wake_detect (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // raw pins
    input wire logic [7:0] pin_i,
    // core side
    gpc_wake_if.det wk
);
    import gpc_pkg::*;

    logic [7:0] meta_r;
    logic [7:0] meta_nxt;
    logic [7:0] sync_r;
    logic [7:0] sync_nxt;
    logic [7:0] prev_r;
    logic [7:0] prev_nxt;
    logic [1:0] fill_r;
    logic [1:0] fill_nxt;

    // first stage is read only by the second stage
    always_comb begin
        meta_nxt = pin_i;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
        fill_nxt = (fill_r == GPC_SYNC_FILL) ? fill_r : fill_r + 2'h1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
            prev_r <= 8'h00;
            fill_r <= 2'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
            fill_r <= fill_nxt;
        end
    end

    // rising or falling, only on enabled pins, only in stop
    // flops reset low, so a pin idling high would look like an edge until the chain has filled
    assign wk.wake_hit = (fill_r == GPC_SYNC_FILL) & wk.stop_mode
                         & (|((sync_r ^ prev_r) & wk.wake_src));

    chk_wake_needs_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wk.wake_hit |-> (sync_r != prev_r) && wk.stop_mode)
        else $error("wake hit without an edge in stop");

endmodule : gpc_wake_detect

// >>> pkg/gpc_pkg.sv
// package: sub-register selector codes, reset values and widths of the pin configuration block
package gpc_pkg;

    // port width, one bit per pin
    localparam int GPC_PINS = 8;
    localparam int GPC_DW = 8;

    // address selector codes
    localparam logic [7:0] GPC_SEL_NONE = 8'h00;
    localparam logic [7:0] GPC_SEL_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] GPC_SEL_WAKE_SRC = 8'h05;
    localparam logic [7:0] GPC_SEL_PULLUP = 8'h06;
    localparam logic [7:0] GPC_SEL_ALT_LOW = 8'h07;
    localparam logic [7:0] GPC_SEL_ALT_HIGH = 8'h08;

    // reset values
    localparam logic [7:0] GPC_RST_SELECTOR = 8'h00;
    localparam logic [7:0] GPC_RST_HIGH_DRIVE = 8'h00;
    localparam logic [7:0] GPC_RST_WAKE_SRC = 8'h00;
    localparam logic [7:0] GPC_RST_PULLUP = 8'h00;
    localparam logic [7:0] GPC_RST_ALT_WIDE = 8'h00;
    localparam logic [7:0] GPC_RST_ALT_SMALL_PORT_A = 8'h04;
    localparam logic [7:0] GPC_READ_UNMAPPED = 8'h00;

    // alternate function select code while the pin is not handed over
    localparam logic [1:0] GPC_ALT_IDLE = 2'h0;

    // edges after reset release until both synchroniser stages and the edge flop hold the pin
    localparam logic [1:0] GPC_SYNC_FILL = 2'h3;

endpackage : gpc_pkg

// >>> pkg/gpc_wake_if.sv
// interface: wake source enables in, recovery hits out, between core and edge detector
`timescale 1ns/1ps
interface gpc_wake_if;
    logic [7:0] wake_src;
    logic stop_mode;
    logic wake_hit;

    modport core (output wake_src, output stop_mode, input wake_hit);
    modport det (input wake_src, input stop_mode, output wake_hit);
endinterface : gpc_wake_if

// >>> test/gpc_pin_model.sv
// board-side model of the eight port pins
`timescale 1ns/1ps
module gpc_pin_model (
    // pins seen by the port
    output logic [7:0] pin_o
);
    // the board holds idle pins high, which the reset-low detector flops see as an edge until the chain has filled
    initial begin
        pin_o = 8'hFF;
    end

    // one logic transition on one pin, either direction
    task automatic toggle(input int idx);
        pin_o[idx] = ~pin_o[idx];
    endtask : toggle
endmodule : gpc_pin_model

// >>> test/gpc_port_cfg_tb_top.sv
// self-checking bench of the pin configuration sub-registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module gpc_port_cfg_tb_top;
    import gpc_pkg::*;
    logic clk_i;
    logic arst_n_i;
    logic sel_wr_i;
    logic [7:0] sel_wdata_i;
    logic [7:0] sel_rdata_o;
    logic win_wr_i;
    logic [7:0] win_wdata_i;
    logic [7:0] win_rdata_o;
    logic [7:0] alt_en;
    logic stop_mode_i;
    logic [7:0] pins;
    logic [7:0] high_drive_o;
    logic [7:0] pullup_en_o;
    logic [7:0] alt_active_o;
    logic [15:0] alt_sel_o;
    logic stop_recover_o;
    logic [7:0] n_wake = 8'h00;
    logic [7:0] rd;
    logic [7:0] win_rdata_a;
    int n_fail;
    int cmp_count;
    logic [7:0] sels [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    logic [7:0] vals [5] = '{8'hA5, 8'h3C, 8'h5A, 8'h0F, 8'h33};
    logic [7:0] bad [4] = '{8'h00, 8'h01, 8'h09, 8'hFF};

    gpc_port_cfg dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .sel_wr_i(sel_wr_i), .sel_wdata_i(sel_wdata_i), .sel_rdata_o(sel_rdata_o),
        .win_wr_i(win_wr_i), .win_wdata_i(win_wdata_i), .win_rdata_o(win_rdata_o),
        .alt_function_enable_bit_i(alt_en), .stop_mode_i(stop_mode_i), .pin_i(pins),
        .high_drive_o(high_drive_o), .pullup_en_o(pullup_en_o), .alt_active_o(alt_active_o),
        .alt_sel_o(alt_sel_o), .stop_recover_o(stop_recover_o)
    );
    // second port strapped as port A of the small package, fed the same stimulus
    gpc_port_cfg #(.SMALL_PORT_A(1'b1)) dut_a (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .sel_wr_i(sel_wr_i), .sel_wdata_i(sel_wdata_i), .sel_rdata_o(),
        .win_wr_i(win_wr_i), .win_wdata_i(win_wdata_i), .win_rdata_o(win_rdata_a),
        .alt_function_enable_bit_i(alt_en), .stop_mode_i(stop_mode_i), .pin_i(pins),
        .high_drive_o(), .pullup_en_o(), .alt_active_o(),
        .alt_sel_o(), .stop_recover_o()
    );
    gpc_pin_model u_pins (
        .pin_o(pins)
    );

    initial begin
        clk_i = 1'b0;
        forever begin
            #10 clk_i = ~clk_i;
        end
    end

    // recovery pulses are one cycle wide, so count them on every edge
    always @(posedge clk_i) begin
        if (stop_recover_o === 1'b1) begin
            n_wake <= n_wake + 8'h01;
        end
    end

    task automatic sel_write(input logic [7:0] v);
        @(negedge clk_i);
        sel_wr_i = 1'b1;
        sel_wdata_i = v;
        @(negedge clk_i);
        sel_wr_i = 1'b0;
    endtask : sel_write

    task automatic win_write(input logic [7:0] v);
        @(negedge clk_i);
        win_wr_i = 1'b1;
        win_wdata_i = v;
        @(negedge clk_i);
        win_wr_i = 1'b0;
    endtask : win_write

    // window read data is registered, so let two edges pass after the last write
    task automatic win_read(input logic [7:0] s, output logic [7:0] v);
        sel_write(s);
        repeat (2) @(negedge clk_i);
        v = win_rdata_o;
    endtask : win_read

    task automatic wake_check(input int idx, input logic [7:0] ex);
        logic [7:0] n0;
        n0 = n_wake;
        @(negedge clk_i);
        u_pins.toggle(idx);
        repeat (8) @(negedge clk_i);
        `CHK("wake pulses", ex, n_wake - n0)
    endtask : wake_check

    function automatic logic [15:0] exp_sel(input logic [7:0] en, input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (en[i]) begin
                r[2*i +: 2] = {hi[i], lo[i]};
            end
        end
        return r;
    endfunction : exp_sel

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end

    initial begin
        arst_n_i = 1'b0;
        sel_wr_i = 1'b0;
        sel_wdata_i = 8'h00;
        win_wr_i = 1'b0;
        win_wdata_i = 8'h00;
        alt_en = 8'h00;
        stop_mode_i = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (8) @(negedge clk_i);
        arst_n_i = 1'b1;
        // reset values of every sub-register
        for (int k = 0; k < 5; k++) begin
            win_read(sels[k], rd);
            `CHK("reset value", 8'h00, rd)
            `CHK("small port reset", (k >= 3) ? GPC_RST_ALT_SMALL_PORT_A : 8'h00, win_rdata_a)
        end
        `CHK("high drive reset", 8'h00, high_drive_o)
        `CHK("pullup reset", 8'h00, pullup_en_o)
        `CHK("alt sel reset", 16'h0000, alt_sel_o)
        $display("test reset_values done");
        // each selector code reaches its own sub-register
        for (int k = 0; k < 5; k++) begin
            sel_write(sels[k]);
            `CHK("selector readback", sels[k], sel_rdata_o)
            win_write(vals[k]);
        end
        for (int k = 0; k < 5; k++) begin
            win_read(sels[k], rd);
            `CHK("window readback", vals[k], rd)
        end
        `CHK("high drive pins", 8'hA5, high_drive_o)
        `CHK("pullup pins", 8'h5A, pullup_en_o)
        $display("test select_routing done");
        // unmapped selector codes drop writes and read zero
        for (int k = 0; k < 4; k++) begin
            sel_write(bad[k]);
            win_write(8'hFF);
            repeat (2) @(negedge clk_i);
            `CHK("unmapped read", 8'h00, win_rdata_o)
        end
        `CHK("high drive kept", 8'hA5, high_drive_o)
        `CHK("pullup kept", 8'h5A, pullup_en_o)
        win_read(8'h07, rd);
        `CHK("alt low kept", 8'h0F, rd)
        $display("test unmapped done");
        // select bits reach a pin only once its enable is set by software
        `CHK("alt sel idle", 16'h0000, alt_sel_o)
        @(negedge clk_i);
        alt_en = 8'h55;
        repeat (2) @(negedge clk_i);
        `CHK("alt active", 8'h55, alt_active_o)
        `CHK("alt sel part", exp_sel(8'h55, 8'h0F, 8'h33), alt_sel_o)
        alt_en = 8'hFF;
        repeat (2) @(negedge clk_i);
        `CHK("alt sel all", exp_sel(8'hFF, 8'h0F, 8'h33), alt_sel_o)
        `CHK("high drive under alt", 8'hA5, high_drive_o)
        $display("test alternate done");
        // stop-mode recovery only from enabled pins and only in stop
        sel_write(8'h05);
        win_write(8'h08);
        stop_mode_i = 1'b1;
        wake_check(3, 8'h01);
        wake_check(3, 8'h01);
        wake_check(2, 8'h00);
        stop_mode_i = 1'b0;
        wake_check(3, 8'h00);
        $display("test stop_recovery done");
        print_verdict();
    end
endmodule : gpc_port_cfg_tb_top
